// File: rtl/dsf_pkg.sv
package dsf_pkg;
    localparam logic [7:0] DSF_STATUS_OFFSET = 8'h6f;
    localparam int DSF_STST_CLOCKS = 1 << 20;
    localparam int DSF_STST_W = 21;
    localparam logic [4:0] DSF_CS_FULL = 5'h1f;
    localparam int DSF_BIT_STST = 31;
    localparam int DSF_BIT_CHOP = 30;
    localparam int DSF_BIT_CS_LO = 16;
    localparam int DSF_BIT_TEMP_LO = 8;
    localparam int DSF_BIT_OPEN_LO = 6;
    localparam int DSF_BIT_LS_LO = 4;
    localparam int DSF_BIT_GS_LO = 2;
    localparam int DSF_BIT_OT = 1;
    localparam int DSF_BIT_OTPW = 0;
    localparam logic [31:0] DSF_STATUS_RESET = 32'h0000_0000;

    // per-mode short flag set: {low_side_b, low_side_a, ground_b, ground_a}
    typedef struct packed {
        logic low_side_short_phase_b;
        logic low_side_short_phase_a;
        logic ground_short_phase_b;
        logic ground_short_phase_a;
    } dsf_shorts_t;

    typedef struct packed {
        logic temp_level_4_flag;
        logic temp_level_3_flag;
        logic temp_level_2_flag;
        logic temp_level_1_flag;
    } dsf_temps_t;
endpackage

// File: rtl/dsf_sync.sv
`timescale 1ns/1ns
module dsf_sync import dsf_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

// File: rtl/dsf_stst.sv
`timescale 1ns/1ns
module dsf_stst import dsf_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // synchronised step level
    input wire logic step_sync,
    // standstill indication
    output logic standstill
);
    logic step_d_reg;
    logic step_d_next;
    logic [DSF_STST_W-1:0] cnt_reg;
    logic [DSF_STST_W-1:0] cnt_next;

    always_comb begin
        step_d_next = step_sync;
        cnt_next = cnt_reg;
        if (step_sync && !step_d_reg) begin
            cnt_next = '0;
        end else if (cnt_reg != DSF_STST_W'(DSF_STST_CLOCKS)) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            step_d_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            step_d_reg <= step_d_next;
            cnt_reg <= cnt_next;
        end
    end

    // saturating counter, so standstill holds until the next step
    assign standstill = (cnt_reg == DSF_STST_W'(DSF_STST_CLOCKS));
endmodule

// File: rtl/dsf_driver_status.sv
`timescale 1ns/1ns
module dsf_driver_status import dsf_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // motion and chopper state from the core
    input wire logic step_in,
    input wire logic voltage_mode_active,
    input wire logic [4:0] current_scale_actual,
    input wire logic [3:0] off_time_field,
    // pins
    input wire logic enable_input_low,
    // analog comparators
    input wire dsf_temps_t temp_levels,
    input wire logic overtemp_limit_raw,
    input wire logic overtemp_warn_raw,
    input wire logic open_load_phase_b_raw,
    input wire logic open_load_phase_a_raw,
    input wire dsf_shorts_t short_detect_raw,
    // register read port
    input wire logic [7:0] reg_addr,
    output logic [31:0] reg_rdata,
    // bridge control
    output logic bridge_enable
);
    logic step_sync;
    logic enn_sync;
    logic standstill;
    logic [11:0] ana_sync;
    dsf_temps_t temps_s;
    logic ot_s;
    logic otpw_s;
    logic olb_s;
    logic ola_s;
    dsf_shorts_t short_s;

    dsf_sync #(.W(2)) u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({step_in, enable_input_low}),
        .q({step_sync, enn_sync})
    );

    // comparators are asynchronous to the core clock
    dsf_sync #(.W(12)) u_ana_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({temp_levels, overtemp_limit_raw, overtemp_warn_raw,
            open_load_phase_b_raw, open_load_phase_a_raw, short_detect_raw}),
        .q(ana_sync)
    );

    assign {temps_s, ot_s, otpw_s, olb_s, ola_s, short_s} = ana_sync;

    dsf_stst u_stst (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .step_sync(step_sync),
        .standstill(standstill)
    );

    // latched shorts, one set per chopper mode
    dsf_shorts_t short_volt_reg;
    dsf_shorts_t short_volt_next;
    dsf_shorts_t short_curr_reg;
    dsf_shorts_t short_curr_next;
    logic ot_latch_reg;
    logic ot_latch_next;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic bridge_en_reg;
    logic bridge_en_next;
    logic driver_off;
    dsf_shorts_t short_view;

    assign driver_off = enn_sync || (off_time_field == 4'h0);

    always_comb begin
        short_volt_next = short_volt_reg;
        short_curr_next = short_curr_reg;
        ot_latch_next = ot_latch_reg;
        if (driver_off) begin
            short_volt_next = '0;
            short_curr_next = '0;
        end else if (voltage_mode_active) begin
            short_volt_next = short_volt_reg | short_s;
        end else begin
            short_curr_next = short_curr_reg | short_s;
        end
        // one shared flag; released only once the warning also clears
        if (ot_s) begin
            ot_latch_next = 1'b1;
        end else if (!otpw_s) begin
            ot_latch_next = 1'b0;
        end
    end

    always_comb begin
        short_view = voltage_mode_active ? short_volt_reg : short_curr_reg;
        status_next = DSF_STATUS_RESET;
        status_next[DSF_BIT_STST] = standstill;
        status_next[DSF_BIT_CHOP] = voltage_mode_active;
        // full 0..31 range passes untouched, 31 is full current
        status_next[DSF_BIT_CS_LO +: 5] = current_scale_actual;
        status_next[DSF_BIT_TEMP_LO +: 4] = temps_s;
        status_next[DSF_BIT_OPEN_LO +: 2] = {olb_s, ola_s};
        status_next[DSF_BIT_LS_LO +: 2] = {short_view.low_side_short_phase_b,
                                           short_view.low_side_short_phase_a};
        status_next[DSF_BIT_GS_LO +: 2] = {short_view.ground_short_phase_b,
                                           short_view.ground_short_phase_a};
        status_next[DSF_BIT_OT] = ot_latch_reg;
        status_next[DSF_BIT_OTPW] = otpw_s;
        // open load deliberately absent from the bridge enable
        bridge_en_next = !driver_off && (short_volt_reg == '0) && (short_curr_reg == '0)
                         && !ot_latch_reg && !ot_s;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            short_volt_reg <= '0;
            short_curr_reg <= '0;
            ot_latch_reg <= 1'b0;
            status_reg <= DSF_STATUS_RESET;
            bridge_en_reg <= 1'b0;
        end else begin
            short_volt_reg <= short_volt_next;
            short_curr_reg <= short_curr_next;
            ot_latch_reg <= ot_latch_next;
            status_reg <= status_next;
            bridge_en_reg <= bridge_en_next;
        end
    end

    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_addr == DSF_STATUS_OFFSET) begin
            rdata_next = status_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign bridge_enable = bridge_en_reg;
endmodule

// File: testbench/dsf_status_asserts.sv
`timescale 1ns/1ns
module dsf_status_asserts import dsf_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // core, pins and comparators
    input wire logic voltage_mode_active,
    input wire logic [4:0] current_scale_actual,
    input wire logic [3:0] off_time_field,
    input wire logic enable_input_low,
    input wire logic overtemp_limit_raw,
    input wire dsf_shorts_t short_detect_raw,
    // read port and bridge
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic bridge_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // status word needs two clean edges before a read reflects same-clock inputs
    sequence s_rd;
        !$past(sys_rst, 2) && !$past(sys_rst) && $past(reg_addr) == DSF_STATUS_OFFSET;
    endsequence
    sequence s_off;
        off_time_field == 4'h0 [*3];
    endsequence
    rsvd_zero_a: assert property (reg_rdata[29:21] == 9'h000 && reg_rdata[15:12] == 4'h0)
        else $error("reserved bits not zero");
    cs_map_a: assert property (s_rd |-> reg_rdata[20:16] == $past(current_scale_actual, 2))
        else $error("current scale field wrong");
    chop_map_a: assert property (s_rd |-> reg_rdata[30] == $past(voltage_mode_active, 2))
        else $error("chopper bit wrong");
    off_bridge_a: assert property (s_off |=> !bridge_enable)
        else $error("bridge on with zero off time");
    pin_bridge_a: assert property (enable_input_low [*4] |=> !bridge_enable)
        else $error("bridge on with enable pin high");
    ot_bridge_a: assert property (overtemp_limit_raw [*4] |=> !bridge_enable)
        else $error("bridge on at overtemperature");
    short_bridge_a: assert property ((short_detect_raw != 4'h0) [*5] |=> !bridge_enable)
        else $error("bridge on after short");
    ot_bit_a: assert property ((overtemp_limit_raw && reg_addr == DSF_STATUS_OFFSET) [*5]
        |=> reg_rdata[1])
        else $error("overtemperature bit not set");
endmodule

bind dsf_driver_status dsf_status_asserts u_chk (.clk_sys, .sys_rst, .voltage_mode_active,
    .current_scale_actual, .off_time_field, .enable_input_low, .overtemp_limit_raw,
    .short_detect_raw, .reg_addr, .reg_rdata, .bridge_enable);

// File: testbench/dsf_host_model.sv
`timescale 1ns/1ns
module dsf_host_model (
    // clock
    input wire logic clk_sys,
    // read port
    input wire logic [31:0] reg_rdata,
    output logic [7:0] reg_addr
);
    initial reg_addr = 8'h00;
    // address is taken at the next edge, data stands after it
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        #1 reg_addr = a;
        @(posedge clk_sys);
        #1 d = reg_rdata;
    endtask
endmodule

// File: testbench/driver_status_flags_bench.sv
`timescale 1ns/1ns
module driver_status_flags_bench import dsf_pkg::*; ;
    logic clk_sys = 1'b0, sys_rst = 1'b1, step_in = 1'b0, voltage_mode_active = 1'b0;
    logic enable_input_low = 1'b0, overtemp_limit_raw = 1'b0, overtemp_warn_raw = 1'b0;
    logic open_load_phase_b_raw = 1'b0, open_load_phase_a_raw = 1'b0, bridge_enable;
    logic [4:0] current_scale_actual = 5'h00;
    logic [3:0] off_time_field = 4'h3;
    dsf_temps_t temp_levels = 4'h0;
    dsf_shorts_t short_detect_raw = 4'h0, sh_vm = 4'h0, sh_cm = 4'h0;
    logic [7:0] reg_addr;
    logic [31:0] reg_rdata, rd;
    logic ot_exp = 1'b0;
    int failures = 0, samples_checked = 0;

    dsf_driver_status u_dut (.clk_sys, .sys_rst, .step_in, .voltage_mode_active,
        .current_scale_actual, .off_time_field, .enable_input_low, .temp_levels,
        .overtemp_limit_raw, .overtemp_warn_raw, .open_load_phase_b_raw,
        .open_load_phase_a_raw, .short_detect_raw, .reg_addr, .reg_rdata, .bridge_enable);
    dsf_host_model u_host (.clk_sys, .reg_rdata, .reg_addr);

    always #4 clk_sys = ~clk_sys;

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // async inputs need four edges to reach the read data, latched shorts and the overtemperature bit five
    task look(input string n);
        logic [31:0] e;
        repeat (6) @(posedge clk_sys);
        e = {1'b0, voltage_mode_active, 9'h000, current_scale_actual, 4'h0, temp_levels,
            open_load_phase_b_raw, open_load_phase_a_raw,
            voltage_mode_active ? sh_vm : sh_cm, ot_exp, overtemp_warn_raw};
        u_host.rd(DSF_STATUS_OFFSET, rd);
        chk(n, rd, e);
        chk({n, " bridge"}, {31'h0, bridge_enable}, {31'h0, off_time_field != 4'h0 &&
            !enable_input_low && sh_vm == 4'h0 && sh_cm == 4'h0 && !ot_exp});
    endtask

    task t_fields;
        for (int i = 0; i < 4; i++) begin
            voltage_mode_active = i[0];
            current_scale_actual = i[0] ? DSF_CS_FULL : 5'(i * 5);
            temp_levels = 4'h1 << i;
            {open_load_phase_b_raw, open_load_phase_a_raw} = i[1:0];
            step_in = ~step_in;
            look("status fields");
        end
        $display("fields done");
    endtask

    task t_unmapped;
        for (int a = 0; a < 3; a++) begin
            u_host.rd(8'h6e + 8'(a * 2), rd);
            chk("unmapped read", rd, 32'h0000_0000);
        end
        $display("unmapped done");
    endtask

    // k selects which of the two disabling actions clears the latched shorts
    task t_shorts;
        for (int k = 0; k < 2; k++) begin
            voltage_mode_active = 1'b0;
            sh_cm = k[0] ? 4'h2 : 4'h8;
            short_detect_raw = sh_cm;
            look("short seen");
            short_detect_raw = 4'h0;
            // the synchroniser still shows the old short for two edges; flip mode only after
            repeat (4) @(posedge clk_sys);
            #1 voltage_mode_active = 1'b1;
            look("other mode clean");
            sh_vm = 4'h5;
            short_detect_raw = sh_vm;
            look("second mode short");
            short_detect_raw = 4'h0;
            repeat (4) @(posedge clk_sys);
            #1 voltage_mode_active = 1'b0;
            look("first set kept");
            if (k[0]) enable_input_low = 1'b1;
            else off_time_field = 4'h0;
            {sh_vm, sh_cm} = 8'h00;
            look("shorts cleared");
            enable_input_low = 1'b0;
            off_time_field = 4'h3;
            look("driver back");
        end
        $display("shorts done");
    endtask

    task t_ot;
        {overtemp_warn_raw, overtemp_limit_raw, ot_exp} = 3'b111;
        look("ot set");
        overtemp_limit_raw = 1'b0;
        look("ot held warm");
        {overtemp_warn_raw, ot_exp} = 2'b00;
        look("ot cleared");
        $display("overtemperature done");
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        look("after reset");
        $display("reset done");
        t_fields;
        t_unmapped;
        t_shorts;
        t_ot;
        report_and_stop;
    end
endmodule
